// File: design/rmm_params.svh
// constants for the relay memory map: offsets, field positions and timing counts
`ifndef RMM_PARAMS_SVH
`define RMM_PARAMS_SVH
`define RMM_NUM_IN 20
`define RMM_NUM_OUT 16
`define RMM_NUM_AUX 59
`define RMM_NUM_LATCH 47
`define RMM_NUM_UNIT 10
`define RMM_PRESET_MAX 255
`define RMM_ADR_IN 8'h00
`define RMM_ADR_OUT 8'h04
`define RMM_ADR_AUX_LO 8'h08
`define RMM_ADR_AUX_HI 8'h0C
`define RMM_ADR_SPEC 8'h10
`define RMM_ADR_LATCH_LO 8'h14
`define RMM_ADR_LATCH_HI 8'h18
`define RMM_ADR_UNIT 8'h1C
`define RMM_ADR_PRESET 8'h20
`define RMM_ADR_COIL 8'h24
`define RMM_ADR_LATCH_SR 8'h28
`define RMM_ADR_STAT 8'h2C
`define RMM_ADR_PRE_BASE 8'h40
`define RMM_ADR_PRE_TOP 8'h8C
`define RMM_SPEC_FIRST 0
`define RMM_SPEC_TENTH 1
`define RMM_SPEC_SEC 2
`define RMM_SPEC_BATTERY 3
`define RMM_SPEC_MEM 4
`define RMM_SPEC_INHIBIT 5
`define RMM_STAT_REJECT 0
`define RMM_STAT_BADNUM 1
`define RMM_CLK_HZ 250000000
`define RMM_TENTH_MS 100
`define RMM_SEC_MS 1000
`define RMM_HALF_TENTH ((`RMM_CLK_HZ / 1000) * `RMM_TENTH_MS / 2)
`define RMM_HALF_SEC ((`RMM_CLK_HZ / 1000) * `RMM_SEC_MS / 2)
`define RMM_FLASH_DIV 5
`endif

// File: design/rmm_pkg.sv
// types for the relay memory map
package rmm_pkg;
   typedef enum logic [1:0] {
      RMM_STOP = 2'b00,
      RMM_FIRST = 2'b01,
      RMM_RUN = 2'b11
   } rmm_mode_t;
endpackage

// File: design/rmm_relay_map.sv
// relay memory map: data memory cells, special relays and wishbone access
//
// Implementation choices: the address map and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "rmm_params.svh"
module rmm_relay_map
   import rmm_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [19:0] in_term_i,
   input wire logic [9:0] timer_done_i,
   input wire logic [9:0] tally_done_i,
   input wire logic mode_run_i,
   input wire logic power_fail_i,
   input wire logic battery_fault_i,
   input wire logic memory_fault_i,
   input wire logic scan_end_i,
   output logic [15:0] out_term_o,
   output logic [15:0] out_lamp_o,
   output logic run_lamp_o,
   output logic cell_low_lamp_o,
   output logic first_scan_flag_o
);
   logic [19:0] in_cell;
   logic [15:0] out_cell;
   logic [58:0] aux_cell;
   logic [46:0] latch_cell;
   logic output_inhibit_relay;
   logic [7:0] preset [0:19];
   logic first_scan_flag;
   logic battery_fault_flag;
   logic memory_fault_flag;
   logic mode_q;
   logic seen_stop;
   rmm_mode_t mode_st;
   rmm_mode_t next_mode_st;
   logic [24:0] tenth_cnt;
   logic [27:0] sec_cnt;
   logic tenth_clk;
   logic sec_clk;
   logic [2:0] flash_cnt;
   logic run_flash;
   logic [1:0] stat;

   // returns true when the low byte lane pair carries a full 16-bit field
   function automatic logic lane_lo(input logic [3:0] sel);
      lane_lo = sel[0] & sel[1];
   endfunction

   // bus decode
   wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire wr_req = bus_req & wb_we_i;
   wire in_pre_rng = (wb_adr_i >= `RMM_ADR_PRE_BASE) && (wb_adr_i <= `RMM_ADR_PRE_TOP);
   wire [7:0] pre_off = wb_adr_i - `RMM_ADR_PRE_BASE;
   wire [4:0] pre_idx = pre_off[6:2];
   wire [7:0] pre_val = wb_dat_i[7:0];
   // a preset of zero or above 255 is refused
   wire pre_bad = (wb_dat_i[31:8] != 24'h000000) || (pre_val == 8'h00);
   // coil command: [7:0] number, [10:8] class, [16] value
   wire [7:0] coil_num = wb_dat_i[7:0];
   wire [2:0] coil_cls = wb_dat_i[10:8];
   wire coil_val = wb_dat_i[16];
   wire coil_wr = wr_req && (wb_adr_i == `RMM_ADR_COIL) && lane_lo(wb_sel_i);
   // class 0 output, 1 auxiliary, other classes refused (special relays included)
   wire coil_out_ok = (coil_cls == 3'h0) && (coil_num < 8'd16);
   wire coil_aux_ok = (coil_cls == 3'h1) && (coil_num < 8'd59);
   wire coil_bad = coil_wr && !(coil_out_ok || coil_aux_ok);
   // latch command: [7:0] number (47 = inhibit relay), [8] set, [9] reset
   wire lsr_wr = wr_req && (wb_adr_i == `RMM_ADR_LATCH_SR) && lane_lo(wb_sel_i);
   wire [7:0] lsr_num = wb_dat_i[7:0];
   wire lsr_set = wb_dat_i[8];
   wire lsr_rst = wb_dat_i[9];
   wire lsr_ok = lsr_num <= 8'd47;
   wire lsr_bad = lsr_wr && !lsr_ok;
   // reset dominates set
   wire lsr_next = lsr_rst ? 1'b0 : (lsr_set ? 1'b1 : 1'b0);
   wire lsr_act = lsr_wr && lsr_ok && !power_fail_i && (lsr_set || lsr_rst);
   wire pre_wr = wr_req && in_pre_rng && (wb_adr_i[1:0] == 2'b00) && wb_sel_i[0];
   wire [5:0] spec_bits = {output_inhibit_relay, memory_fault_flag, battery_fault_flag,
                           sec_clk, tenth_clk, first_scan_flag};
   wire mapped = (wb_adr_i <= `RMM_ADR_STAT) || (in_pre_rng && (wb_adr_i[1:0] == 2'b00));
   wire [31:0] rd_mux =
      (wb_adr_i == `RMM_ADR_IN) ? {12'h000, in_cell} :
      (wb_adr_i == `RMM_ADR_OUT) ? {16'h0000, out_cell} :
      (wb_adr_i == `RMM_ADR_AUX_LO) ? aux_cell[31:0] :
      (wb_adr_i == `RMM_ADR_AUX_HI) ? {5'h00, aux_cell[58:32]} :
      (wb_adr_i == `RMM_ADR_SPEC) ? {26'h0000000, spec_bits} :
      (wb_adr_i == `RMM_ADR_LATCH_LO) ? latch_cell[31:0] :
      (wb_adr_i == `RMM_ADR_LATCH_HI) ? {17'h00000, latch_cell[46:32]} :
      (wb_adr_i == `RMM_ADR_UNIT) ? {12'h000, tally_done_i, timer_done_i} :
      (wb_adr_i == `RMM_ADR_STAT) ? {30'h00000000, stat} :
      in_pre_rng ? {24'h000000, preset[pre_idx]} : 32'h00000000;

   // wishbone answer, one cycle after the request, dropped the next
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= bus_req;
         wb_dat_o <= (bus_req && !wb_we_i && mapped) ? rd_mux : 32'h00000000;
      end
   end

   // input cells follow their terminals
   always_ff @(posedge clk_i) begin
      if (rst_i) in_cell <= 20'h00000;
      else in_cell <= in_term_i;
   end

   // output and auxiliary coil writes, one cell per number
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         out_cell <= 16'h0000;
         aux_cell <= 59'h0;
      end else if (coil_wr) begin
         if (coil_out_ok) out_cell[coil_num[3:0]] <= coil_val;
         if (coil_aux_ok) aux_cell[coil_num[5:0]] <= coil_val;
      end
   end

   // latching cells hold through power fail; rst_i is the cold start only
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         latch_cell <= 47'h0;
         output_inhibit_relay <= 1'b0;
      end else if (lsr_act) begin
         if (lsr_num == 8'd47) output_inhibit_relay <= lsr_next;
         else latch_cell[lsr_num[5:0]] <= lsr_next;
      end
   end

   // preset storage: timers 0-9 then counters 0-9
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < 20; i++) preset[i] <= 8'h01;
      end else if (pre_wr && !pre_bad && (pre_idx < 5'd20)) begin
         preset[pre_idx] <= pre_val;
      end
   end

   // sticky refusal flags, cleared by writing one; a new refusal wins
   wire stat_clr = wr_req && (wb_adr_i == `RMM_ADR_STAT) && wb_sel_i[0];
   wire rej_ev = pre_wr && pre_bad;
   wire bad_ev = coil_bad || lsr_bad;
   wire rej_keep = stat[`RMM_STAT_REJECT] & ~(stat_clr & wb_dat_i[0]);
   wire bad_keep = stat[`RMM_STAT_BADNUM] & ~(stat_clr & wb_dat_i[1]);
   always_ff @(posedge clk_i) begin
      if (rst_i) stat <= 2'b00;
      else begin
         stat[`RMM_STAT_REJECT] <= rej_ev | rej_keep;
         stat[`RMM_STAT_BADNUM] <= bad_ev | bad_keep;
      end
   end

   // mode sequencing: first scan after a stop-to-run change
   always_comb begin
      next_mode_st = mode_st;
      case (mode_st)
         RMM_STOP: if (mode_run_i && seen_stop) next_mode_st = RMM_FIRST;
         RMM_FIRST: if (scan_end_i) next_mode_st = RMM_RUN;
         RMM_RUN: if (!mode_run_i) next_mode_st = RMM_STOP;
         default: next_mode_st = RMM_STOP;
      endcase
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_st <= RMM_STOP;
         mode_q <= 1'b0;
         seen_stop <= 1'b0;
         first_scan_flag <= 1'b0;
      end else begin
         mode_st <= next_mode_st;
         mode_q <= mode_run_i;
         if (!mode_run_i) seen_stop <= 1'b1;
         first_scan_flag <= (next_mode_st == RMM_FIRST);
      end
   end

   // fault flags: battery follows its fault, memory holds until mode change
   wire mode_chg = mode_q ^ mode_run_i;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         battery_fault_flag <= 1'b0;
         memory_fault_flag <= 1'b0;
      end else begin
         battery_fault_flag <= battery_fault_i;
         memory_fault_flag <= memory_fault_i | (memory_fault_flag & ~mode_chg);
      end
   end

   // clock relays by division, toggling each half period
   wire tenth_wrap = (tenth_cnt == 25'(`RMM_HALF_TENTH - 1));
   wire sec_wrap = (sec_cnt == 28'(`RMM_HALF_SEC - 1));
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tenth_cnt <= 25'h0;
         sec_cnt <= 28'h0;
         tenth_clk <= 1'b0;
         sec_clk <= 1'b0;
      end else begin
         tenth_cnt <= tenth_wrap ? 25'h0 : tenth_cnt + 25'h1;
         sec_cnt <= sec_wrap ? 28'h0 : sec_cnt + 28'h1;
         if (tenth_wrap) tenth_clk <= ~tenth_clk;
         if (sec_wrap) sec_clk <= ~sec_clk;
      end
   end

   // run lamp flash at one toggle per five 0.1 s half-periods
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flash_cnt <= 3'h0;
         run_flash <= 1'b0;
      end else if (tenth_wrap) begin
         flash_cnt <= (flash_cnt == 3'(`RMM_FLASH_DIV - 1)) ? 3'h0 : flash_cnt + 3'h1;
         if (flash_cnt == 3'(`RMM_FLASH_DIV - 1)) run_flash <= ~run_flash;
      end
   end

   // terminal and lamp drive; inhibit and power fail blank the outputs
   wire out_blank = output_inhibit_relay | power_fail_i;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         out_term_o <= 16'h0000;
         out_lamp_o <= 16'h0000;
         run_lamp_o <= 1'b0;
         cell_low_lamp_o <= 1'b0;
         first_scan_flag_o <= 1'b0;
      end else begin
         out_term_o <= out_blank ? 16'h0000 : out_cell;
         out_lamp_o <= out_blank ? 16'h0000 : out_cell;
         run_lamp_o <= (mode_st != RMM_STOP) &
                       (output_inhibit_relay ? run_flash : 1'b1);
         cell_low_lamp_o <= battery_fault_i;
         first_scan_flag_o <= first_scan_flag;
      end
   end

   // checks: output blanking under the inhibit relay and recovery after it
   a_inhibit_blanks: assert property (@(posedge clk_i) disable iff (rst_i)
      output_inhibit_relay |=> (out_term_o == 16'h0000) && (out_lamp_o == 16'h0000))
      else $error("outputs not blanked while inhibited");
   a_outputs_follow: assert property (@(posedge clk_i) disable iff (rst_i)
      (!output_inhibit_relay && !power_fail_i) |=> (out_term_o == $past(out_cell)))
      else $error("outputs do not follow program result");
   a_lamps_match: assert property (@(posedge clk_i) disable iff (rst_i)
      out_lamp_o == out_term_o)
      else $error("output lamps disagree with terminals");
   a_run_lamp_steady: assert property (@(posedge clk_i) disable iff (rst_i)
      (mode_st != RMM_STOP && !output_inhibit_relay) |=> run_lamp_o)
      else $error("run lamp not steady while running");
   a_run_lamp_flash: assert property (@(posedge clk_i) disable iff (rst_i)
      (mode_st != RMM_STOP && output_inhibit_relay) |=> (run_lamp_o == $past(run_flash)))
      else $error("run lamp not flashing while inhibited");

   // power fail blanks the outputs and leaves every latch as it was
   a_fail_blanks: assert property (@(posedge clk_i) disable iff (rst_i)
      power_fail_i |=> (out_term_o == 16'h0000) && (out_lamp_o == 16'h0000))
      else $error("outputs not off during power fail");
   a_fail_keeps_latch: assert property (@(posedge clk_i) disable iff (rst_i)
      power_fail_i |=> $stable(latch_cell) && $stable(output_inhibit_relay))
      else $error("latch changed during power fail");

   // latch commands: reset dominates set, a lone set stores a one
   a_reset_wins: assert property (@(posedge clk_i) disable iff (rst_i)
      (lsr_act && lsr_rst && lsr_num < 8'd47) |=> !latch_cell[$past(lsr_num[5:0])])
      else $error("set beat reset on a latch");
   a_latch_set: assert property (@(posedge clk_i) disable iff (rst_i)
      (lsr_act && lsr_set && !lsr_rst && lsr_num < 8'd47) |=> latch_cell[$past(lsr_num[5:0])])
      else $error("latch set was lost");

   // first-scan flag: only during the first scan, gone once it ends
   a_first_scan_once: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(first_scan_flag) |-> (mode_st == RMM_FIRST))
      else $error("first scan flag outside first scan");
   a_first_scan_ends: assert property (@(posedge clk_i) disable iff (rst_i)
      (mode_st == RMM_FIRST && scan_end_i) |=> !first_scan_flag)
      else $error("first scan flag outlived its scan");
   a_first_scan_stop: assert property (@(posedge clk_i) disable iff (rst_i)
      (mode_st == RMM_STOP) |-> !first_scan_flag)
      else $error("first scan flag set in stop");
   a_first_scan_out: assert property (@(posedge clk_i) disable iff (rst_i)
      first_scan_flag |=> first_scan_flag_o)
      else $error("first scan output missed the flag");

   // fault flags: battery follows its fault, memory holds until mode change
   a_mem_fault_set: assert property (@(posedge clk_i) disable iff (rst_i)
      memory_fault_i |=> memory_fault_flag)
      else $error("memory fault not flagged");
   a_mem_fault_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      (memory_fault_flag && !mode_chg) |=> memory_fault_flag)
      else $error("memory fault released without mode change");
   a_mem_fault_clear: assert property (@(posedge clk_i) disable iff (rst_i)
      (mode_chg && !memory_fault_i) |=> !memory_fault_flag)
      else $error("memory fault kept after mode change");
   a_bat_lamp_follow: assert property (@(posedge clk_i) disable iff (rst_i)
      1'b1 |=> (cell_low_lamp_o == $past(battery_fault_i))
         && (battery_fault_flag == cell_low_lamp_o))
      else $error("battery lamp and flag disagree with fault");

   // coil and latch numbers: refusals flagged, cells untouched
   a_special_no_coil: assert property (@(posedge clk_i) disable iff (rst_i)
      (coil_wr && coil_cls > 3'h1) |=> $stable(aux_cell) && $stable(out_cell)
         && stat[`RMM_STAT_BADNUM])
      else $error("special relay written as coil");
   a_bad_coil_kept: assert property (@(posedge clk_i) disable iff (rst_i)
      coil_bad |=> $stable(out_cell) && $stable(aux_cell))
      else $error("refused coil number changed a cell");
   a_bad_num_flag: assert property (@(posedge clk_i) disable iff (rst_i)
      (coil_bad || lsr_bad) |=> stat[`RMM_STAT_BADNUM])
      else $error("refused relay number not flagged");
   a_coil_stored: assert property (@(posedge clk_i) disable iff (rst_i)
      (coil_wr && coil_out_ok) |=> (out_cell[$past(coil_num[3:0])] == $past(coil_val)))
      else $error("output coil write not stored in its cell");

   // presets: a refused value is flagged and never stored
   a_bad_preset_kept: assert property (@(posedge clk_i) disable iff (rst_i)
      (pre_wr && pre_bad && pre_idx < 5'd20)
         |=> (preset[$past(pre_idx)] == $past(preset[pre_idx])))
      else $error("refused preset was stored");
   a_reject_flag: assert property (@(posedge clk_i) disable iff (rst_i)
      (pre_wr && pre_bad) |=> stat[`RMM_STAT_REJECT])
      else $error("refused preset not flagged");

   // clock relays toggle at each half period; inputs and bus answer
   a_tenth_toggle: assert property (@(posedge clk_i) disable iff (rst_i)
      tenth_wrap |=> (tenth_clk != $past(tenth_clk)) && (tenth_cnt == 25'h0))
      else $error("0.1 s clock did not toggle at half period");
   a_sec_toggle: assert property (@(posedge clk_i) disable iff (rst_i)
      sec_wrap |=> (sec_clk != $past(sec_clk)) && (sec_cnt == 28'h0))
      else $error("1 s clock did not toggle at half period");
   a_input_follow: assert property (@(posedge clk_i) disable iff (rst_i)
      1'b1 |=> (in_cell == $past(in_term_i)))
      else $error("input cells do not follow terminals");
   a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("bus answer longer than one cycle");
   a_ack_needs_req: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |-> $past(bus_req))
      else $error("bus answer without a request");
endmodule
`default_nettype wire

// File: verification/rmm_io_model.sv
// terminal blocks and controller inputs seen by the relay memory map
`timescale 1ns/1ps
`default_nettype none
module rmm_io_model (
   input wire logic clk_i,
   output logic [19:0] in_term_o,
   output logic [9:0] timer_done_o,
   output logic [9:0] tally_done_o,
   output logic mode_run_o,
   output logic power_fail_o,
   output logic battery_fault_o,
   output logic memory_fault_o,
   output logic scan_end_o
);
   // everything idle at power-up, mode switch in stop
   initial begin
      {in_term_o, timer_done_o, tally_done_o} = '0;
      {mode_run_o, power_fail_o, battery_fault_o, memory_fault_o, scan_end_o} = '0;
   end
   // change one input group right after an edge; terminal n drives bit n
   task put(input int k, input logic [19:0] v);
      @(posedge clk_i);
      case (k)
         0: in_term_o <= v;
         1: timer_done_o <= v[9:0];
         2: tally_done_o <= v[9:0];
         3: mode_run_o <= v[0];
         4: power_fail_o <= v[0];
         5: battery_fault_o <= v[0];
         6: memory_fault_o <= v[0];
         default: ;
      endcase
   endtask
   // one-cycle end-of-scan pulse from the program side
   task scan();
      @(posedge clk_i);
      scan_end_o <= 1'b1;
      @(posedge clk_i);
      scan_end_o <= 1'b0;
   endtask
endmodule
`default_nettype wire

// File: verification/tb.sv
// register-level test of the relay memory map
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, fs, rl, bl;
   logic [7:0] adr = 8'h00;
   logic [31:0] wd = 32'h0, rdat, q;
   logic [19:0] it;
   logic [9:0] td, cd;
   logic run_sw, pf, bf, mf, se;
   logic [15:0] ot, ol;
   int n_errors = 0, n_tests = 0;
   always #2 clk_i = ~clk_i;
   rmm_io_model io (.clk_i(clk_i), .in_term_o(it), .timer_done_o(td), .tally_done_o(cd),
      .mode_run_o(run_sw), .power_fail_o(pf), .battery_fault_o(bf), .memory_fault_o(mf),
      .scan_end_o(se));
   rmm_relay_map DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(rdat),
      .wb_ack_o(ack), .in_term_i(it), .timer_done_i(td), .tally_done_i(cd),
      .mode_run_i(run_sw), .power_fail_i(pf), .battery_fault_i(bf), .memory_fault_i(mf),
      .scan_end_i(se), .out_term_o(ot), .out_lamp_o(ol), .run_lamp_o(rl),
      .cell_low_lamp_o(bl), .first_scan_flag_o(fs));
   task final_report();
      $display("checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         n_errors++;
         $display("Error t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   // one classic cycle, held until ack is sampled high
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wd <= d;
      i = 0;
      do begin
         @(posedge clk_i);
         i++;
      end while (ack !== 1'b1 && i < 50);
      if (i >= 50) begin
         n_errors++;
         final_report();
      end
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(q & m, e);
   endtask
   task wait_n(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task done(input string s);
      $display("test %s done, mismatches %0d", s, n_errors);
   endtask
   initial begin
      wait_n(5);
      rst_i <= 1'b0;
      rdc(8'h10, 32'h3F, 32'h0);
      rdc(8'h40, 32'hFF, 32'h1);
      io.put(0, 20'hA5C3F);
      io.put(1, 20'h201);
      io.put(2, 20'h3FF);
      bus(1'b1, 8'h00, 32'h0);
      rdc(8'h00, 32'hFFFFFFFF, 32'h000A5C3F);
      rdc(8'h1C, 32'hFFFFFFFF, 32'h000FFE01);
      rdc(8'h3C, 32'hFFFFFFFF, 32'h0);
      done("inputs");
      // coils written once each, output 15 used as storage
      bus(1'b1, 8'h24, 32'h00010000);
      bus(1'b1, 8'h24, 32'h0001000F);
      bus(1'b1, 8'h24, 32'h0001013A);
      rdc(8'h04, 32'hFFFFFFFF, 32'h00008001);
      chk({16'h0, ot}, 32'h8001);
      rdc(8'h0C, 32'hFFFFFFFF, 32'h04000000);
      bus(1'b1, 8'h24, 32'h0001013B);
      rdc(8'h2C, 32'h3, 32'h2);
      bus(1'b1, 8'h2C, 32'h3);
      bus(1'b1, 8'h24, 32'h0001023B);
      rdc(8'h2C, 32'h3, 32'h2);
      rdc(8'h0C, 32'hFFFFFFFF, 32'h04000000);
      bus(1'b1, 8'h2C, 32'h3);
      bus(1'b1, 8'h24, 32'h00010010);
      rdc(8'h2C, 32'h3, 32'h2);
      rdc(8'h04, 32'hFFFFFFFF, 32'h00008001);
      bus(1'b1, 8'h2C, 32'h3);
      done("coils");
      bus(1'b1, 8'h40, 32'h100);
      rdc(8'h2C, 32'h3, 32'h1);
      bus(1'b1, 8'h2C, 32'h3);
      bus(1'b1, 8'h8C, 32'hFF);
      rdc(8'h8C, 32'hFF, 32'hFF);
      rdc(8'h2C, 32'h3, 32'h0);
      bus(1'b1, 8'h84, 32'h0);
      rdc(8'h2C, 32'h3, 32'h1);
      bus(1'b1, 8'h2C, 32'h3);
      done("presets");
      bus(1'b1, 8'h28, 32'h12E);
      bus(1'b1, 8'h28, 32'h103);
      bus(1'b1, 8'h28, 32'h303);
      rdc(8'h14, 32'hFFFFFFFF, 32'h0);
      rdc(8'h18, 32'hFFFFFFFF, 32'h4000);
      io.put(4, 20'h1);
      wait_n(3);
      chk({ot, ol}, 32'h0);
      io.put(4, 20'h0);
      wait_n(3);
      rdc(8'h18, 32'hFFFFFFFF, 32'h4000);
      done("latches");
      io.put(5, 20'h1);
      wait_n(3);
      rdc(8'h10, 32'h39, 32'h08);
      chk({31'h0, bl}, 32'h1);
      io.put(5, 20'h0);
      wait_n(3);
      rdc(8'h10, 32'h39, 32'h0);
      chk({31'h0, bl}, 32'h0);
      io.put(3, 20'h1);
      wait_n(3);
      rdc(8'h10, 32'h39, 32'h1);
      chk({31'h0, fs}, 32'h1);
      io.scan();
      wait_n(3);
      rdc(8'h10, 32'h39, 32'h0);
      done("flags");
      bus(1'b1, 8'h28, 32'h12F);
      wait_n(2);
      rdc(8'h10, 32'h39, 32'h20);
      chk({ot, ol}, 32'h0);
      bus(1'b1, 8'h28, 32'h22F);
      wait_n(2);
      chk({ot, ol}, 32'h80018001);
      chk({31'h0, rl}, 32'h1);
      io.put(6, 20'h1);
      io.put(6, 20'h0);
      wait_n(2);
      rdc(8'h10, 32'h39, 32'h10);
      io.put(3, 20'h0);
      wait_n(3);
      rdc(8'h10, 32'h39, 32'h0);
      done("inhibit");
      final_report();
   end
endmodule
`default_nettype wire
